/* File: hdl/csrbd_cfg.svh */
// constants for the card status and read binary command block
`ifndef CSRBD_CFG_SVH
`define CSRBD_CFG_SVH
// register byte offsets
`define CSRBD_CTRL 8'h00
`define CSRBD_FILE_ID 8'h04
`define CSRBD_SFH_OBJ 8'h08
`define CSRBD_LCS 8'h0c
`define CSRBD_PIN_CFG 8'h10
`define CSRBD_KEY_REF 8'h14
`define CSRBD_DIR_NAME 8'h18
`define CSRBD_STATE 8'h1c
`define CSRBD_FILE_BASE 8'h40
// object tags and fixed values
`define CSRBD_TAG_FCP 8'h62
`define CSRBD_TAG_SFH 8'h88
`define CSRBD_TAG_LCS 8'h8a
`define CSRBD_TAG_PIN 8'hc6
`define CSRBD_TAG_BITMAP 8'h90
`define CSRBD_TAG_UQ 8'h95
`define CSRBD_TAG_KEY 8'h83
`define CSRBD_TAG_DIRNAME 8'h84
`define CSRBD_LEN_ONE 8'h01
`define CSRBD_LEN_NONE 8'h00
`define CSRBD_DIRNAME_LEN 8'h04
`define CSRBD_UNIV_PIN 8'h11
// command codes and parameters
`define CSRBD_INS_STATUS 8'hf2
`define CSRBD_INS_READ 8'hb0
`define CSRBD_P2_SELECT 8'h00
`define CSRBD_P2_DIRNAME 8'h01
`define CSRBD_P2_NODATA 8'h0c
`define CSRBD_P1_MAX 8'h02
`define CSRBD_P1_SFH_MODE 3'h4
// status words
`define CSRBD_SW_OK 16'h9000
`define CSRBD_SW_LEN 16'h6700
`define CSRBD_SW_P1P2 16'h6a86
`define CSRBD_SW_DENIED 16'h6982
`define CSRBD_SW_NOFILE 16'h6a82
`define CSRBD_SW_RANGE 16'h6b00
`define CSRBD_SW_INS 16'h6d00
// sizes
`define CSRBD_FILE_BYTES 16
`define CSRBD_FILE_LEN 16'h0010
`define CSRBD_TMPL_BYTES 32
`endif

/* File: hdl/csrbd_pkg.sv */
// types for the card status and read binary command block
package csrbd_pkg;
    typedef enum logic [2:0] {
        CSRBD_IDLE = 3'b001,
        CSRBD_SEND = 3'b010,
        CSRBD_DONE = 3'b100
    } csrbd_state_t;
    typedef enum logic [1:0] {
        CSRBD_SRC_FCP = 2'h0,
        CSRBD_SRC_DIR = 2'h1,
        CSRBD_SRC_FILE = 2'h2
    } csrbd_src_t;
    typedef enum logic [2:0] {
        CSRBD_LC_NONE = 3'h0,
        CSRBD_LC_CREATE = 3'h1,
        CSRBD_LC_INIT = 3'h2,
        CSRBD_LC_OP_ACT = 3'h3,
        CSRBD_LC_OP_DEACT = 3'h4,
        CSRBD_LC_TERM = 3'h5,
        CSRBD_LC_PROP = 3'h6,
        CSRBD_LC_RFU = 3'h7
    } csrbd_lcs_t;
endpackage : csrbd_pkg

/* File: hdl/csrbd_top.sv */
// status and read binary command decoder with control-parameter objects
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "csrbd_cfg.svh"

module csrbd_top
    import csrbd_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire logic [7:0] cmd_ins_i,
    input wire logic [7:0] cmd_p1_i,
    input wire logic [7:0] cmd_p2_i,
    input wire logic cmd_lc_present_i,
    input wire logic cmd_le_present_i,
    input wire logic [7:0] cmd_le_i,
    output logic rsp_valid_o,
    output logic [7:0] rsp_data_o,
    input wire logic rsp_ready_i,
    output logic sw_valid_o,
    output logic [15:0] sw_o
);
    logic read_ok_r;
    logic [15:0] file_id_r;
    logic sfh_present_r, sfh_len1_r;
    logic [7:0] sfh_byte_r, lcs_r, bitmap_r, key0_r, key1_r, uq0_r, uq1_r;
    logic [1:0] key_cnt_r, uq_en_r, indic_r;
    logic [31:0] dirname_r;
    logic [7:0] file_mem_r [`CSRBD_FILE_BYTES];
    logic [15:0] sw_r;
    csrbd_state_t state_r;
    csrbd_src_t src_r, dec_src;
    logic [15:0] off_r, dec_off;
    logic [8:0] len_r, cnt_r, dec_len;
    logic [15:0] dec_sw;
    logic rsp_valid_r, sw_valid_r;
    logic [7:0] rsp_data_r;
    logic sfh_sup;
    logic [4:0] sfh_val;
    csrbd_lcs_t lcs_code;
    logic [7:0] tmpl [`CSRBD_TMPL_BYTES];
    logic [8:0] tmpl_len;
    logic [4:0] lcs_pos, pin_pos;
    logic [7:0] next_byte;
    logic accept, step;

    // register writes; the file content is loaded in the separate block below
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            read_ok_r <= 1'b0;
            file_id_r <= 16'h0000;
            sfh_present_r <= 1'b0;
            sfh_len1_r <= 1'b0;
            sfh_byte_r <= 8'h00;
            lcs_r <= 8'h00;
            bitmap_r <= 8'h00;
            key_cnt_r <= 2'h0;
            uq_en_r <= 2'h0;
            {uq1_r, uq0_r, key1_r, key0_r} <= 32'h0000_0000;
            dirname_r <= 32'h0000_0000;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `CSRBD_CTRL: read_ok_r <= reg_wdata_i[0];
                `CSRBD_FILE_ID: file_id_r <= reg_wdata_i[15:0];
                `CSRBD_SFH_OBJ: begin
                    sfh_present_r <= reg_wdata_i[0];
                    sfh_len1_r <= reg_wdata_i[1];
                    sfh_byte_r <= reg_wdata_i[15:8];
                end
                `CSRBD_LCS: lcs_r <= reg_wdata_i[7:0];
                `CSRBD_PIN_CFG: begin
                    bitmap_r <= reg_wdata_i[7:0];
                    key_cnt_r <= reg_wdata_i[9:8];
                    uq_en_r <= reg_wdata_i[11:10];
                end
                `CSRBD_KEY_REF: {uq1_r, uq0_r, key1_r, key0_r} <= reg_wdata_i;
                `CSRBD_DIR_NAME: dirname_r <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    // file bytes sit one per word; storage has no reset to keep it small
    always_ff @(posedge clk_i) begin
        if (reg_wr_i && reg_addr_i[7:6] == `CSRBD_FILE_BASE >> 6) begin
            file_mem_r[reg_addr_i[5:2]] <= reg_wdata_i[7:0];
        end
    end

    // read data stands in the cycle after the strobe only
    always_ff @(posedge clk_i) begin
        if (reset_i || !reg_rd_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else begin
            case (reg_addr_i)
                `CSRBD_CTRL: reg_rdata_o <= {31'h0, read_ok_r};
                `CSRBD_FILE_ID: reg_rdata_o <= {16'h0, file_id_r};
                `CSRBD_SFH_OBJ: reg_rdata_o <= {16'h0, sfh_byte_r, 6'h0, sfh_len1_r, sfh_present_r};
                `CSRBD_LCS: reg_rdata_o <= {24'h0, lcs_r};
                `CSRBD_PIN_CFG: reg_rdata_o <= {20'h0, uq_en_r, key_cnt_r, bitmap_r};
                `CSRBD_KEY_REF: reg_rdata_o <= {uq1_r, uq0_r, key1_r, key0_r};
                `CSRBD_DIR_NAME: reg_rdata_o <= dirname_r;
                // live state: last status word, key enables, indication, handle, life cycle
                `CSRBD_STATE: reg_rdata_o <= {sw_r, 3'h0, bitmap_r[7], bitmap_r[6], indic_r,
                                              sfh_sup, sfh_val, lcs_code};
                default: begin
                    if (reg_addr_i[7:6] == `CSRBD_FILE_BASE >> 6) begin
                        reg_rdata_o <= {24'h0, file_mem_r[reg_addr_i[5:2]]};
                    end else begin
                        reg_rdata_o <= 32'h0000_0000;
                    end
                end
            endcase
        end
    end

    // short handle: malformed one-byte value counts as unsupported
    always_comb begin
        if (!sfh_present_r) begin
            sfh_sup = 1'b1;
            sfh_val = file_id_r[4:0];
        end else if (!sfh_len1_r) begin
            sfh_sup = 1'b0;
            sfh_val = 5'h00;
        end else begin
            sfh_sup = (sfh_byte_r[2:0] == 3'h0);
            sfh_val = sfh_byte_r[7:3];
        end
    end

    // life-cycle byte decode
    always_comb begin
        if (lcs_r[7:4] != 4'h0) lcs_code = CSRBD_LC_PROP;
        else if (lcs_r == 8'h00) lcs_code = CSRBD_LC_NONE;
        else if (lcs_r == 8'h01) lcs_code = CSRBD_LC_CREATE;
        else if (lcs_r == 8'h03) lcs_code = CSRBD_LC_INIT;
        else if (lcs_r[3:2] == 2'b11) lcs_code = CSRBD_LC_TERM;
        else if (lcs_r[3:2] == 2'b01) begin
            lcs_code = lcs_r[0] ? CSRBD_LC_OP_ACT : CSRBD_LC_OP_DEACT;
        end else lcs_code = CSRBD_LC_RFU;
    end

    // control-parameter template, rebuilt whenever software changes a field
    always_comb begin
        int p;
        int lp;
        logic [7:0] key;
        p = 2;
        lp = 0;
        key = 8'h00;
        for (int i = 0; i < `CSRBD_TMPL_BYTES; i++) tmpl[i] = 8'h00;
        tmpl[0] = `CSRBD_TAG_FCP;
        if (sfh_present_r) begin
            tmpl[p] = `CSRBD_TAG_SFH;
            tmpl[p + 1] = sfh_len1_r ? `CSRBD_LEN_ONE : `CSRBD_LEN_NONE;
            p = p + 2;
            if (sfh_len1_r) begin
                tmpl[p] = sfh_byte_r;
                p = p + 1;
            end
        end
        lcs_pos = 5'(p);
        tmpl[p] = `CSRBD_TAG_LCS;
        tmpl[p + 1] = `CSRBD_LEN_ONE;
        tmpl[p + 2] = lcs_r;
        p = p + 3;
        pin_pos = 5'(p);
        tmpl[p] = `CSRBD_TAG_PIN;
        lp = p + 1;
        tmpl[p + 2] = `CSRBD_TAG_BITMAP;
        tmpl[p + 3] = `CSRBD_LEN_ONE;
        tmpl[p + 4] = bitmap_r;
        p = p + 5;
        // one key object per pin, qualifier first when needed
        for (int k = 0; k < 2; k++) begin
            if (k < int'(key_cnt_r)) begin
                key = (k == 0) ? key0_r : key1_r;
                if (key == `CSRBD_UNIV_PIN || uq_en_r[k]) begin
                    tmpl[p] = `CSRBD_TAG_UQ;
                    tmpl[p + 1] = `CSRBD_LEN_ONE;
                    tmpl[p + 2] = (k == 0) ? uq0_r : uq1_r;
                    p = p + 3;
                end
                tmpl[p] = `CSRBD_TAG_KEY;
                tmpl[p + 1] = `CSRBD_LEN_ONE;
                tmpl[p + 2] = key;
                p = p + 3;
            end
        end
        tmpl[lp] = 8'(p - lp - 1);
        tmpl[1] = 8'(p - 2);
        tmpl_len = 9'(p);
    end

    // command decode; reserved encodings win over access and range checks
    always_comb begin
        logic [8:0] want;
        want = (cmd_le_i == 8'h00) ? 9'h100 : {1'b0, cmd_le_i};
        dec_sw = `CSRBD_SW_OK;
        dec_len = 9'h000;
        dec_src = CSRBD_SRC_FCP;
        dec_off = 16'h0000;
        case (cmd_ins_i)
            `CSRBD_INS_STATUS: begin
                if (cmd_p1_i > `CSRBD_P1_MAX) begin
                    dec_sw = `CSRBD_SW_P1P2;
                end else if (cmd_p2_i == `CSRBD_P2_SELECT) begin
                    dec_len = tmpl_len;
                end else if (cmd_p2_i == `CSRBD_P2_DIRNAME) begin
                    dec_src = CSRBD_SRC_DIR;
                    dec_len = 9'({`CSRBD_DIRNAME_LEN} + 8'h02);
                end else if (cmd_p2_i != `CSRBD_P2_NODATA) begin
                    dec_sw = `CSRBD_SW_P1P2;
                end
                // a nonzero le caps the answer
                if (cmd_le_present_i && cmd_le_i != 8'h00 && want < dec_len) begin
                    dec_len = want;
                end
            end
            `CSRBD_INS_READ: begin
                dec_src = CSRBD_SRC_FILE;
                if (!cmd_p1_i[7]) begin
                    dec_off = {1'b0, cmd_p1_i[6:0], cmd_p2_i};
                end else if (cmd_p1_i[7:5] == `CSRBD_P1_SFH_MODE) begin
                    dec_off = {8'h00, cmd_p2_i};
                    if (!sfh_sup || cmd_p1_i[4:0] != sfh_val) begin
                        dec_sw = `CSRBD_SW_NOFILE;
                    end
                end else begin
                    dec_sw = `CSRBD_SW_P1P2;
                end
                if (dec_sw != `CSRBD_SW_OK) begin
                    dec_len = 9'h000;
                end else if (cmd_lc_present_i || !cmd_le_present_i) begin
                    dec_sw = `CSRBD_SW_LEN;
                end else if (!read_ok_r) begin
                    dec_sw = `CSRBD_SW_DENIED;
                end else if (dec_off + {7'h00, want} > `CSRBD_FILE_LEN) begin
                    dec_sw = `CSRBD_SW_RANGE;
                end else begin
                    dec_len = want;
                end
            end
            default: dec_sw = `CSRBD_SW_INS;
        endcase
        if (dec_sw != `CSRBD_SW_OK) dec_len = 9'h000;
    end

    assign cmd_ready_o = (state_r == CSRBD_IDLE);
    assign accept = cmd_valid_i && cmd_ready_o;
    assign step = (state_r == CSRBD_SEND) && (!rsp_valid_r || rsp_ready_i);

    // next answer byte by position
    always_comb begin
        case (src_r)
            CSRBD_SRC_FILE: next_byte = file_mem_r[4'(off_r + {7'h00, cnt_r})];
            CSRBD_SRC_DIR: begin
                case (cnt_r[2:0])
                    3'h0: next_byte = `CSRBD_TAG_DIRNAME;
                    3'h1: next_byte = `CSRBD_DIRNAME_LEN;
                    3'h2: next_byte = dirname_r[31:24];
                    3'h3: next_byte = dirname_r[23:16];
                    3'h4: next_byte = dirname_r[15:8];
                    default: next_byte = dirname_r[7:0];
                endcase
            end
            default: next_byte = tmpl[cnt_r[4:0]];
        endcase
    end

    // sequencer: take command, stream bytes, then give the status word
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_r <= CSRBD_IDLE;
            src_r <= CSRBD_SRC_FCP;
            off_r <= 16'h0000;
            len_r <= 9'h000;
            cnt_r <= 9'h000;
            sw_r <= `CSRBD_SW_OK;
            indic_r <= 2'h0;
        end else begin
            case (state_r)
                CSRBD_IDLE: begin
                    if (accept) begin
                        src_r <= dec_src;
                        off_r <= dec_off;
                        len_r <= dec_len;
                        cnt_r <= 9'h000;
                        sw_r <= dec_sw;
                        if (cmd_ins_i == `CSRBD_INS_STATUS && dec_sw == `CSRBD_SW_OK) begin
                            indic_r <= cmd_p1_i[1:0];
                        end
                        state_r <= CSRBD_SEND;
                    end
                end
                CSRBD_SEND: begin
                    if (step && cnt_r == len_r) state_r <= CSRBD_DONE;
                    else if (step) cnt_r <= cnt_r + 9'h001;
                end
                CSRBD_DONE: state_r <= CSRBD_IDLE;
                default: state_r <= CSRBD_IDLE;
            endcase
        end
    end

    // byte output register, held until the terminal takes it
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rsp_valid_r <= 1'b0;
            rsp_data_r <= 8'h00;
        end else if (step) begin
            rsp_valid_r <= (cnt_r != len_r);
            if (cnt_r != len_r) rsp_data_r <= next_byte;
        end
    end

    // status word pulse once the last byte has gone
    always_ff @(posedge clk_i) begin
        if (reset_i) sw_valid_r <= 1'b0;
        else sw_valid_r <= (state_r == CSRBD_DONE);
    end

    assign rsp_valid_o = rsp_valid_r;
    assign rsp_data_o = rsp_data_r;
    assign sw_valid_o = sw_valid_r;
    assign sw_o = sw_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    sfh_absent_a: assert property (!sfh_present_r |-> sfh_sup && sfh_val == file_id_r[4:0])
        else $error("handle not taken from file identifier");
    sfh_empty_a: assert property (sfh_present_r && !sfh_len1_r |-> !sfh_sup)
        else $error("empty handle object still supported");
    sfh_byte_a: assert property (sfh_present_r && sfh_len1_r |-> sfh_val == sfh_byte_r[7:3]
        && sfh_sup == (sfh_byte_r[2:0] == 3'h0))
        else $error("one-byte handle misdecoded");
    lcs_object_a: assert property (tmpl[lcs_pos] == 8'h8a && tmpl[lcs_pos + 5'h01] == 8'h01
        && tmpl[lcs_pos + 5'h02] == lcs_r)
        else $error("life-cycle object malformed");
    lcs_decode_a: assert property (lcs_r == 8'h05 |-> lcs_code == CSRBD_LC_OP_ACT)
        else $error("life-cycle decode wrong");
    pin_head_a: assert property (tmpl[pin_pos] == 8'hc6 && tmpl[pin_pos + 5'h02] == 8'h90
        && tmpl[pin_pos + 5'h04] == bitmap_r)
        else $error("pin template head malformed");
    univ_qual_a: assert property (key_cnt_r != 2'h0 && key0_r == 8'h11
        |-> tmpl[pin_pos + 5'h05] == 8'h95 && tmpl[pin_pos + 5'h08] == 8'h83)
        else $error("universal pin lacks qualifier");
    status_none_a: assert property (accept && cmd_ins_i == 8'hf2 && cmd_p1_i == 8'h00
        && cmd_p2_i == 8'h0c |=> len_r == 9'h000 ##2 sw_valid_o && sw_o == 16'h9000)
        else $error("no-data status answered wrongly");
    read_denied_a: assert property (accept && cmd_ins_i == 8'hb0 && !read_ok_r
        && cmd_p1_i[7] == 1'b0 && cmd_le_present_i && !cmd_lc_present_i
        |=> sw_r == 16'h6982 && len_r == 9'h000)
        else $error("read without access not refused");
    read_offset_a: assert property (accept && cmd_ins_i == 8'hb0 && !cmd_p1_i[7]
        |=> off_r == {1'b0, $past(cmd_p1_i[6:0]), $past(cmd_p2_i)})
        else $error("read offset wrong");
    read_count_a: assert property (accept && cmd_ins_i == 8'hb0 && dec_sw == 16'h9000
        |=> len_r == (($past(cmd_le_i) == 8'h00) ? 9'h100 : {1'b0, $past(cmd_le_i)}))
        else $error("read byte count wrong");
    reserved_p1_a: assert property (accept && cmd_ins_i == 8'hb0 && cmd_p1_i[7:5] == 3'h5
        |=> sw_r == 16'h6a86 && len_r == 9'h000 ##1 !rsp_valid_o)
        else $error("reserved p1 not refused");

    status_fcp_c: cover property (accept && cmd_ins_i == 8'hf2 && cmd_p2_i == 8'h00);
    read_sfh_c: cover property (accept && cmd_ins_i == 8'hb0 && dec_src == CSRBD_SRC_FILE
        && cmd_p1_i[7] && dec_sw == 16'h9000);
    stall_c: cover property (rsp_valid_o && !rsp_ready_i ##1 rsp_valid_o && rsp_ready_i);
endmodule : csrbd_top
`default_nettype wire

/* File: tb/csrbd_term.sv */
// terminal model on the answer side: takes bytes promptly or slowly
`timescale 1ns/100ps
`default_nettype none
module csrbd_term (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic stall_i,
    input wire logic rsp_valid_i,
    output logic rsp_ready_o
);
    logic [2:0] cnt_r;
    // slow mode takes one beat in four, so each byte must stand until taken
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cnt_r <= 3'h0;
            rsp_ready_o <= 1'b0;
        end else begin
            cnt_r <= cnt_r + 3'h1;
            rsp_ready_o <= !stall_i || (cnt_r[1:0] == 2'h0);
        end
    end
endmodule : csrbd_term
`default_nettype wire

/* File: tb/csrbd_top_test.sv */
// self-checking bench for the status and read binary block
`timescale 1ns/100ps
`default_nettype none
`include "csrbd_cfg.svh"
module csrbd_top_test;
    logic clk_i = 1'b0, reset_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, cmd_valid_i = 1'b0;
    logic cmd_lc_present_i = 1'b0, cmd_le_present_i = 1'b0, stall = 1'b0;
    logic [7:0] reg_addr_i = 8'h00, cmd_ins_i = 8'h00, cmd_p1_i = 8'h00, cmd_p2_i = 8'h00;
    logic [7:0] cmd_le_i = 8'h00, rsp_data_o;
    logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, rv, fid, sfo, pcfg, kref, dname;
    logic [15:0] sw_o;
    logic cmd_ready_o, rsp_valid_o, rsp_ready, sw_valid_o;
    logic [7:0] file [16];
    logic [7:0] ex[$], got[$], pt[$];
    logic [5:0] h;
    int mismatches = 0, checked = 0, seed = 32'h4d06ed2b, r, off, n, k, i;
    csrbd_top csrbd_top_i (.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
        .cmd_ins_i(cmd_ins_i), .cmd_p1_i(cmd_p1_i), .cmd_p2_i(cmd_p2_i),
        .cmd_lc_present_i(cmd_lc_present_i), .cmd_le_present_i(cmd_le_present_i),
        .cmd_le_i(cmd_le_i), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
        .rsp_ready_i(rsp_ready), .sw_valid_o(sw_valid_o), .sw_o(sw_o));
    csrbd_term csrbd_term_i (.clk_i(clk_i), .reset_i(reset_i), .stall_i(stall),
        .rsp_valid_i(rsp_valid_o), .rsp_ready_o(rsp_ready));
    // 40 MHz clock
    initial begin
        forever #12.5 clk_i = !clk_i;
    end
    task automatic wrap_up;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask : rd
    // command held until accepted; bytes gathered at handshake edges until the status word
    task automatic cmd(input logic [7:0] ins, p1, p2, input logic lcp, lep, input logic [7:0] le);
        int w;
        @(posedge clk_i);
        cmd_ins_i <= ins;
        cmd_p1_i <= p1;
        cmd_p2_i <= p2;
        cmd_lc_present_i <= lcp;
        cmd_le_present_i <= lep;
        cmd_le_i <= le;
        cmd_valid_i <= 1'b1;
        got = {};
        w = 0;
        do @(posedge clk_i); while (cmd_ready_o !== 1'b1 && ++w < 50);
        cmd_valid_i <= 1'b0;
        w = 0;
        while (sw_valid_o !== 1'b1 && w < 2000) begin
            @(posedge clk_i);
            if (rsp_valid_o === 1'b1 && rsp_ready === 1'b1) got.push_back(rsp_data_o);
            w++;
        end
        if (w >= 50 * 40) mismatches++;
    endtask : cmd
    task automatic chkr(input logic [15:0] sw);
        chk("status word", {16'h0, sw_o}, {16'h0, sw});
        chk("byte count", got.size(), ex.size());
        foreach (ex[j]) if (j < got.size()) chk("answer byte", {24'h0, got[j]}, {24'h0, ex[j]});
    endtask : chkr
    // expected {supported, handle} from identifier and handle object
    function automatic logic [5:0] hnd();
        if (!sfo[0]) return {1'b1, fid[4:0]};
        if (!sfo[1]) return 6'h00;
        return {sfo[10:8] == 3'h0, sfo[15:11]};
    endfunction : hnd
    function automatic logic [2:0] lcx(input logic [7:0] v);
        if (v[7:4] != 4'h0) return 3'h6;
        casez (v[3:0])
            4'b0000: return 3'h0;
            4'b0001: return 3'h1;
            4'b0011: return 3'h2;
            4'b01?1: return 3'h3;
            4'b01?0: return 3'h4;
            4'b11??: return 3'h5;
            default: return 3'h7;
        endcase
    endfunction : lcx
    // whole answer to a status request for control parameters
    task automatic tmpl(input logic [7:0] lc);
        ex = {};
        // two branches, since a queue concatenation inside ?: would be read as a packed vector
        if (sfo[0] && sfo[1]) begin
            ex = {8'h88, 8'h01, sfo[15:8]};
        end else if (sfo[0]) begin
            ex = {8'h88, 8'h00};
        end
        ex = {ex, 8'h8a, 8'h01, lc};
        pt = {8'h90, 8'h01, pcfg[7:0]};
        for (int q = 0; q < pcfg[9:8]; q++) begin
            if (kref[8*q+:8] == 8'h11 || pcfg[10+q]) pt = {pt, 8'h95, 8'h01, kref[16+8*q+:8]};
            pt = {pt, 8'h83, 8'h01, kref[8*q+:8]};
        end
        ex = {8'h62, 8'(ex.size() + 2 + pt.size()), ex, 8'hc6, 8'(pt.size()), pt};
    endtask : tmpl
    // watchdog sized well above the expected run
    initial begin
        #(25 * 60000);
        mismatches++;
        wrap_up();
    end
    initial begin
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        rd(`CSRBD_STATE, rv);
        chk("state after reset", rv[31:16], 32'h9000);
        rd(8'h30, rv);
        chk("unmapped read", rv, 32'h0);
        for (i = 0; i < 16; i++) begin
            file[i] = 8'($random(seed));
            wr(8'h40 + 8'(4 * i), {24'h0, file[i]});
        end
        ex = {};
        cmd(`CSRBD_INS_READ, 8'h00, 8'h00, 1'b0, 1'b1, 8'h04);
        chkr(16'h6982);
        wr(`CSRBD_CTRL, 32'h1);
        for (k = 0; k < 8; k++) begin
            r = $random(seed);
            stall <= r[8];
            off = r[3:0];
            n = (r[7:4] % (16 - off)) + 1;
            ex = {};
            for (i = 0; i < n; i++) ex.push_back(file[off + i]);
            cmd(`CSRBD_INS_READ, 8'h00, 8'(off), 1'b0, 1'b1, 8'(n));
            chkr(16'h9000);
        end
        ex = {};
        cmd(`CSRBD_INS_READ, 8'h00, 8'h0f, 1'b0, 1'b1, 8'h02);
        chkr(16'h6b00);
        cmd(`CSRBD_INS_READ, 8'h01, 8'h00, 1'b0, 1'b1, 8'h01);
        chkr(16'h6b00);
        cmd(`CSRBD_INS_READ, 8'h00, 8'h00, 1'b1, 1'b1, 8'h01);
        chkr(16'h6700);
        cmd(`CSRBD_INS_READ, 8'h00, 8'h00, 1'b0, 1'b0, 8'h01);
        chkr(16'h6700);
        cmd(`CSRBD_INS_READ, 8'ha0, 8'h00, 1'b0, 1'b1, 8'h01);
        chkr(16'h6a86);
        cmd(8'ha4, 8'h00, 8'h00, 1'b0, 1'b1, 8'h01);
        chkr(16'h6d00);
        // handle absent, empty, one byte, malformed one byte
        for (k = 0; k < 4; k++) begin
            r = $random(seed);
            fid = {16'h0, r[15:0]};
            sfo = (k == 0) ? 32'h0 : (k == 1) ? 32'h1 : {16'h0, r[23:19], (k == 3) ? 3'h5 : 3'h0, 8'h3};
            wr(`CSRBD_FILE_ID, fid);
            wr(`CSRBD_SFH_OBJ, sfo);
            h = hnd();
            rd(`CSRBD_STATE, rv);
            chk("handle supported", rv[8], h[5]);
            if (h[5]) chk("handle", rv[7:3], h[4:0]);
            ex = {};
            if (h[5]) ex = {file[1]};
            cmd(`CSRBD_INS_READ, {3'h4, h[4:0]}, 8'h01, 1'b0, 1'b1, 8'h01);
            chkr(h[5] ? 16'h9000 : 16'h6a82);
            ex = {};
            cmd(`CSRBD_INS_READ, {3'h4, h[4:0] ^ 5'h1}, 8'h01, 1'b0, 1'b1, 8'h01);
            chkr(16'h6a82);
        end
        foreach (pt[j]) pt[j] = 8'h0;
        pt = {8'h00, 8'h01, 8'h03, 8'h05, 8'h07, 8'h04, 8'h06, 8'h0c, 8'h0f, 8'h10, 8'hf3, 8'h02, 8'h08};
        foreach (pt[j]) begin
            wr(`CSRBD_LCS, {24'h0, pt[j]});
            rd(`CSRBD_STATE, rv);
            chk("life cycle", rv[2:0], lcx(pt[j]));
        end
        for (k = 0; k < 3; k++) begin
            r = $random(seed);
            pcfg = {20'h0, r[11:10] & {2{k[0]}}, k[0] ? 2'h1 : 2'h2, r[7:0]};
            kref = $random(seed);
            if (k == 0) kref[7:0] = 8'h11;
            dname = $random(seed);
            wr(`CSRBD_PIN_CFG, pcfg);
            wr(`CSRBD_KEY_REF, kref);
            wr(`CSRBD_DIR_NAME, dname);
            rd(`CSRBD_STATE, rv);
            chk("key enables", rv[12:11], pcfg[7:6]);
            tmpl(8'h08); // life-cycle byte left by the last write of the decode sweep
            cmd(`CSRBD_INS_STATUS, 8'h00, 8'h00, 1'b0, 1'b0, 8'h00);
            chkr(16'h9000);
            ex = ex[0:2];
            cmd(`CSRBD_INS_STATUS, 8'h00, 8'h00, 1'b0, 1'b1, 8'h03);
            chkr(16'h9000);
            ex = {8'h84, 8'h04, dname[31:24], dname[23:16], dname[15:8], dname[7:0]};
            cmd(`CSRBD_INS_STATUS, 8'h00, 8'h01, 1'b0, 1'b1, 8'h00);
            chkr(16'h9000);
        end
        ex = {};
        for (k = 0; k < 4; k++) begin
            cmd(`CSRBD_INS_STATUS, 8'(k), 8'h0c, 1'b0, 1'b0, 8'h00);
            chkr(k < 3 ? 16'h9000 : 16'h6a86);
            rd(`CSRBD_STATE, rv);
            if (k < 3) chk("status indication", rv[10:9], k);
        end
        cmd(`CSRBD_INS_STATUS, 8'h00, 8'h02, 1'b0, 1'b0, 8'h00);
        chkr(16'h6a86);
        wrap_up();
    end
endmodule : csrbd_top_test
`default_nettype wire
